/* File: hdl/pps_seq_defines.svh */
`ifndef PPS_SEQ_DEFINES_SVH
`define PPS_SEQ_DEFINES_SVH

// Core clock rate and derived millisecond divider
`define PPS_CLK_HZ 10000000
`define PPS_MS_PER_S 1000
`define PPS_MS_CYCLES (`PPS_CLK_HZ / `PPS_MS_PER_S)

// Start-up sequence times, in milliseconds
`define PPS_CHECK_AT_MS 50
`define PPS_DONE_AT_MS 100

// Thermal sample period, in milliseconds (plain default)
`define PPS_THERM_PERIOD_MS 100

// Worst-case gate disable after system undervoltage, in microseconds
`define PPS_SYSUV_MAX_US 500

// Register byte offsets
`define PPS_CFG_OFFSET 4'h0
`define PPS_STATUS_OFFSET 4'h4

// Config register fields
`define PPS_CFG_HV_INHIBIT_BIT 0
`define PPS_CFG_LV_LOAD_BIT 1
`define PPS_CFG_THERM_LOAD_BIT 2
`define PPS_CFG_RESET 3'h0

// Status register fields
`define PPS_ST_DONE_BIT 0
`define PPS_ST_CHK_LV_BIT 1
`define PPS_ST_CHK_HV_BIT 2
`define PPS_ST_CHK_OCD_BIT 3
`define PPS_ST_CHK_SCD_BIT 4
`define PPS_ST_REG_EN_BIT 5
`define PPS_ST_CHG_BIT 6
`define PPS_ST_DSG_BIT 7
`define PPS_ST_FAULT_BIT 8

// AXI response codes
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2

`endif

/* File: hdl/pps_pkg.sv */
package pps_pkg;

  // Sequencer and protection states
  typedef enum logic [2:0] {
    PPS_CHECK,
    PPS_NORMAL,
    PPS_HV_FAULT,
    PPS_LV_FAULT,
    PPS_OT_FAULT,
    PPS_LOAD_FAULT,
    PPS_SHUTDOWN
  } pps_state_t;

  // Analog-side levels arriving on pins, all asynchronous
  typedef struct packed {
    logic supply_sag;
    logic charge_gate_reservoir_low;
    logic discharge_gate_reservoir_low;
    logic sys_undervoltage;
    logic cell_low_voltage_raw;
    logic cell_high_voltage_raw;
    logic overcurrent_in_discharge_raw;
    logic short_in_discharge_raw;
    logic cell_low_voltage;
    logic cell_high_voltage;
    logic low_voltage_cleared;
    logic high_voltage_cleared;
    logic load_present;
    logic charger_detect;
    logic below_hot_limit;
    logic above_hot_clear;
    logic late_fault;
  } pps_pins_t;

  // Software configuration bits
  typedef struct packed {
    logic thermal_recovery_select;
    logic low_voltage_recovery_load_select;
    logic high_voltage_charger_inhibit_select;
  } pps_cfg_t;

  // Faults caught by the start-up check
  typedef struct packed {
    logic short_in_discharge;
    logic overcurrent_in_discharge;
    logic cell_high_voltage;
    logic cell_low_voltage;
  } pps_chk_t;

endpackage : pps_pkg

/* File: hdl/pps_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pps_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : pps_sync

`default_nettype wire

/* File: hdl/pps_sequencer.sv */
// Contract
// - Supply sag beyond holdup drives both gates low.
// - Either gate reservoir below minimum level turns both FETs off.
// - System undervoltage disables both gates well within 500 us.
// - Same start-up check on power-up and on charger wake from shutdown.
// - A start-up fault enters its protection state, not normal operation.
// - Start-up check begins only after internal reset release.
// - Before completion gates held low, both clear-margin selects forced high.
// - At 50 ms one check pulse samples four raw comparators.
// - A sampled comparator fault sets its internal status bit.
// - Further 50 ms lets corrupt samples recover; complete at 100 ms.
// - Fault-free completion returns gates and margin selects to normal.
// - Late faults are evaluated only after the start-up sequence.
// - Check only from regulator-off or internal reset, no other path.
// - High voltage: charge off, discharge on, optional thermistor pull-low.
// - Low voltage: both off, recover above hysteresis, charger enables charge.
// - Load-select set: low-voltage recovery also needs the load removed.
// - Hot for one to two sample periods: both off; recover above hysteresis.
// - Low-voltage state: charger detection turns charge gate on regardless.
// - Shutdown turns regulator and both gates off; both clear-margin selects stay high.
`timescale 1ns/1ns
`default_nettype none
`include "pps_seq_defines.svh"

module pps_sequencer #(
  parameter int MS_CYCLES = `PPS_MS_CYCLES,
  parameter int THERM_PERIOD_MS = `PPS_THERM_PERIOD_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Analog comparator and sense levels
  input wire pps_pkg::pps_pins_t pins_in,
  // Gate drives and analog controls
  output logic charge_gate,
  output logic discharge_gate,
  output logic regulator_en,
  output logic low_voltage_clear_margin_sel,
  output logic high_voltage_clear_margin_sel,
  output logic startup_check_pulse,
  output logic startup_complete,
  // Thermistor pin pull-low (open drain)
  output logic thermistor_sense_out,
  output logic thermistor_sense_oe,
  // AXI4-Lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);
  localparam int TH_W = $clog2(THERM_PERIOD_MS + 1);
  localparam logic [6:0] CHECK_LAST = 7'(`PPS_CHECK_AT_MS - 1);
  localparam logic [6:0] DONE_LAST = 7'(`PPS_DONE_AT_MS - 1);

  pps_pkg::pps_pins_t pins_s;
  logic [$bits(pps_pkg::pps_pins_t)-1:0] pins_q;
  pps_pkg::pps_state_t state_r, state_nxt;
  pps_pkg::pps_cfg_t cfg_r;
  pps_pkg::pps_chk_t chk_r, chk_live;
  logic [MS_W-1:0] div_r;
  logic ms_tick;
  logic [6:0] seq_ms_r;
  logic [TH_W-1:0] th_cnt_r;
  logic therm_tick;
  logic hot_prev_r;
  logic restart;
  logic seq_done;
  logic gate_kill;
  logic chg_nxt, dsg_nxt;
  logic aw_hold_r, w_hold_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;

  // Every pin level is asynchronous to core_clk
  pps_sync #(
    .W($bits(pps_pkg::pps_pins_t))
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(pins_in),
    .q(pins_q)
  );
  assign pins_s = pps_pkg::pps_pins_t'(pins_q);

  // Word decode shared by reads and writes
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
    hit = (addr[3:2] == offset[3:2]);
  endfunction : hit

  // Sequence restarts when leaving shutdown; reset restarts it as well
  assign restart = (state_r == pps_pkg::PPS_SHUTDOWN) && (state_nxt == pps_pkg::PPS_CHECK);
  assign ms_tick = (div_r == MS_W'(MS_CYCLES - 1));
  assign seq_done = (state_r == pps_pkg::PPS_CHECK) && ms_tick && (seq_ms_r == DONE_LAST);

  // Millisecond divider, cleared by reset and by sequence restart
  always_ff @(posedge core_clk)
  begin
    if (rst || restart)
      div_r <= '0;
    else if (ms_tick)
      div_r <= '0;
    else
      div_r <= div_r + MS_W'(1);
  end

  // Milliseconds since the sequence began
  always_ff @(posedge core_clk)
  begin
    if (rst || restart)
      seq_ms_r <= '0;
    else if ((state_r == pps_pkg::PPS_CHECK) && ms_tick)
      seq_ms_r <= seq_ms_r + 7'h01;
  end

  // Thermal sample period built from millisecond ticks
  assign therm_tick = ms_tick && (th_cnt_r == TH_W'(THERM_PERIOD_MS - 1));
  always_ff @(posedge core_clk)
  begin
    if (rst)
      th_cnt_r <= '0;
    else if (therm_tick)
      th_cnt_r <= '0;
    else if (ms_tick)
      th_cnt_r <= th_cnt_r + TH_W'(1);
  end

  // Previous hot sample; two hot samples in a row give 1-2 periods of filtering
  always_ff @(posedge core_clk)
  begin
    if (rst)
      hot_prev_r <= 1'b0;
    else if (therm_tick)
      hot_prev_r <= pins_s.below_hot_limit;
  end

  // Check pulse exactly once, at the 50 ms point
  always_ff @(posedge core_clk)
  begin
    if (rst)
      startup_check_pulse <= 1'b0;
    else
      startup_check_pulse <= (state_r == pps_pkg::PPS_CHECK) && ms_tick && (seq_ms_r == CHECK_LAST);
  end

  // Fault bits: set from unfiltered comparators at the pulse, cleared on restart
  always_ff @(posedge core_clk)
  begin
    if (rst || restart)
      chk_r <= '0;
    else if (startup_check_pulse)
    begin
      chk_r.cell_low_voltage <= pins_s.cell_low_voltage_raw;
      chk_r.cell_high_voltage <= pins_s.cell_high_voltage_raw;
      chk_r.overcurrent_in_discharge <= pins_s.overcurrent_in_discharge_raw;
      chk_r.short_in_discharge <= pins_s.short_in_discharge_raw;
    end
  end

  // A sample that was corrupt drops out if the comparator is clear at the end
  always_comb
  begin
    chk_live.cell_low_voltage = chk_r.cell_low_voltage && pins_s.cell_low_voltage_raw;
    chk_live.cell_high_voltage = chk_r.cell_high_voltage && pins_s.cell_high_voltage_raw;
    chk_live.overcurrent_in_discharge = chk_r.overcurrent_in_discharge && pins_s.overcurrent_in_discharge_raw;
    chk_live.short_in_discharge = chk_r.short_in_discharge && pins_s.short_in_discharge_raw;
  end

  // State transitions; undervoltage shutdown overrides everything
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      pps_pkg::PPS_CHECK:
      begin
        if (seq_done)
        begin
          if (chk_live.overcurrent_in_discharge || chk_live.short_in_discharge)
            state_nxt = pps_pkg::PPS_LOAD_FAULT;
          else if (chk_live.cell_low_voltage)
            state_nxt = pps_pkg::PPS_LV_FAULT;
          else if (chk_live.cell_high_voltage)
            state_nxt = pps_pkg::PPS_HV_FAULT;
          else
            state_nxt = pps_pkg::PPS_NORMAL;
        end
      end
      pps_pkg::PPS_NORMAL:
      begin
        // Late faults looked at here and in load-fault recovery, after the sequence
        if (pins_s.late_fault)
          state_nxt = pps_pkg::PPS_LOAD_FAULT;
        else if (pins_s.cell_low_voltage)
          state_nxt = pps_pkg::PPS_LV_FAULT;
        else if (pins_s.cell_high_voltage)
          state_nxt = pps_pkg::PPS_HV_FAULT;
        else if (therm_tick && pins_s.below_hot_limit && hot_prev_r)
          state_nxt = pps_pkg::PPS_OT_FAULT;
      end
      pps_pkg::PPS_HV_FAULT:
      begin
        if (pins_s.high_voltage_cleared)
          state_nxt = pps_pkg::PPS_NORMAL;
      end
      pps_pkg::PPS_LV_FAULT:
      begin
        if (pins_s.low_voltage_cleared &&
            (!cfg_r.low_voltage_recovery_load_select || !pins_s.load_present))
          state_nxt = pps_pkg::PPS_NORMAL;
      end
      pps_pkg::PPS_OT_FAULT:
      begin
        if (therm_tick && pins_s.above_hot_clear &&
            (!cfg_r.thermal_recovery_select || !pins_s.load_present))
          state_nxt = pps_pkg::PPS_NORMAL;
      end
      pps_pkg::PPS_LOAD_FAULT:
      begin
        if (!pins_s.late_fault && !pins_s.load_present)
          state_nxt = pps_pkg::PPS_NORMAL;
      end
      pps_pkg::PPS_SHUTDOWN:
      begin
        // Only a charger wakes the regulator and reruns the check
        if (pins_s.charger_detect && !pins_s.sys_undervoltage)
          state_nxt = pps_pkg::PPS_CHECK;
      end
    endcase
    if (pins_s.sys_undervoltage)
      state_nxt = pps_pkg::PPS_SHUTDOWN;
  end

  // State register; reset starts the sequence
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= pps_pkg::PPS_CHECK;
    else
      state_r <= state_nxt;
  end

  // Gate values per state
  always_comb
  begin
    chg_nxt = 1'b0;
    dsg_nxt = 1'b0;
    unique case (state_r)
      pps_pkg::PPS_CHECK:
      begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b0;
      end
      pps_pkg::PPS_NORMAL:
      begin
        chg_nxt = 1'b1;
        dsg_nxt = 1'b1;
      end
      pps_pkg::PPS_HV_FAULT:
      begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b1;
      end
      pps_pkg::PPS_LV_FAULT:
      begin
        chg_nxt = pins_s.charger_detect;
        dsg_nxt = 1'b0;
      end
      pps_pkg::PPS_OT_FAULT, pps_pkg::PPS_LOAD_FAULT:
      begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b0;
      end
      pps_pkg::PPS_SHUTDOWN:
      begin
        chg_nxt = 1'b0;
        dsg_nxt = 1'b0;
      end
    endcase
  end

  // Supply or reservoir collapse kills the gates before the state reacts
  assign gate_kill = pins_s.supply_sag || pins_s.charge_gate_reservoir_low ||
                     pins_s.discharge_gate_reservoir_low || pins_s.sys_undervoltage;

  // Gate drive registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      charge_gate <= 1'b0;
      discharge_gate <= 1'b0;
    end
    else if (gate_kill)
    begin
      charge_gate <= 1'b0;
      discharge_gate <= 1'b0;
    end
    else
    begin
      charge_gate <= chg_nxt;
      discharge_gate <= dsg_nxt;
    end
  end

  // Completion flag and hysteresis-forcing margin selects
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      startup_complete <= 1'b0;
      low_voltage_clear_margin_sel <= 1'b1;
      high_voltage_clear_margin_sel <= 1'b1;
    end
    else
    begin
      startup_complete <= (state_nxt != pps_pkg::PPS_CHECK) && (state_nxt != pps_pkg::PPS_SHUTDOWN);
      // Normal mode clears without margin; any fault state keeps hysteresis
      low_voltage_clear_margin_sel <= (state_nxt != pps_pkg::PPS_NORMAL);
      high_voltage_clear_margin_sel <= (state_nxt != pps_pkg::PPS_NORMAL);
    end
  end

  // Regulator stays on except in shutdown
  always_ff @(posedge core_clk)
  begin
    if (rst)
      regulator_en <= 1'b1;
    else
      regulator_en <= (state_nxt != pps_pkg::PPS_SHUTDOWN);
  end

  // Thermistor pin pulled low in high-voltage fault; follows state_r so it never leads the charge gate off
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      thermistor_sense_out <= 1'b0;
      thermistor_sense_oe <= 1'b0;
    end
    else
    begin
      thermistor_sense_out <= 1'b0;
      thermistor_sense_oe <= (state_r == pps_pkg::PPS_HV_FAULT) &&
                             cfg_r.high_voltage_charger_inhibit_select;
    end
  end

  // Write address and data held until both are present
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
      // Reopen only after the response is taken: one write in flight
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response and config register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPS_RESP_OKAY;
      cfg_r <= `PPS_CFG_RESET;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr_r, `PPS_CFG_OFFSET))
      begin
        s_axi_bresp <= `PPS_RESP_OKAY;
        if (w_strb_r[0])
        begin
          cfg_r.high_voltage_charger_inhibit_select <= w_data_r[`PPS_CFG_HV_INHIBIT_BIT];
          cfg_r.low_voltage_recovery_load_select <= w_data_r[`PPS_CFG_LV_LOAD_BIT];
          cfg_r.thermal_recovery_select <= w_data_r[`PPS_CFG_THERM_LOAD_BIT];
        end
      end
      else if (hit(aw_addr_r, `PPS_STATUS_OFFSET))
        s_axi_bresp <= `PPS_RESP_OKAY;
      else
        s_axi_bresp <= `PPS_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPS_RESP_OKAY;
      if (hit(s_axi_araddr, `PPS_CFG_OFFSET))
      begin
        s_axi_rdata[`PPS_CFG_HV_INHIBIT_BIT] <= cfg_r.high_voltage_charger_inhibit_select;
        s_axi_rdata[`PPS_CFG_LV_LOAD_BIT] <= cfg_r.low_voltage_recovery_load_select;
        s_axi_rdata[`PPS_CFG_THERM_LOAD_BIT] <= cfg_r.thermal_recovery_select;
      end
      else if (hit(s_axi_araddr, `PPS_STATUS_OFFSET))
      begin
        s_axi_rdata[`PPS_ST_DONE_BIT] <= startup_complete;
        s_axi_rdata[`PPS_ST_CHK_LV_BIT] <= chk_r.cell_low_voltage;
        s_axi_rdata[`PPS_ST_CHK_HV_BIT] <= chk_r.cell_high_voltage;
        s_axi_rdata[`PPS_ST_CHK_OCD_BIT] <= chk_r.overcurrent_in_discharge;
        s_axi_rdata[`PPS_ST_CHK_SCD_BIT] <= chk_r.short_in_discharge;
        s_axi_rdata[`PPS_ST_REG_EN_BIT] <= regulator_en;
        s_axi_rdata[`PPS_ST_CHG_BIT] <= charge_gate;
        s_axi_rdata[`PPS_ST_DSG_BIT] <= discharge_gate;
        s_axi_rdata[`PPS_ST_FAULT_BIT] <= (state_r != pps_pkg::PPS_NORMAL) &&
                                         (state_r != pps_pkg::PPS_CHECK);
      end
      else
        s_axi_rresp <= `PPS_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : pps_sequencer

`default_nettype wire

/* File: bench/pps_seq_sva.sv */
`timescale 1ns/1ns
`default_nettype none

module pps_seq_sva #(
  parameter int MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin levels and controls
  input wire pps_pkg::pps_pins_t pins_in,
  input wire logic charge_gate,
  input wire logic discharge_gate,
  input wire logic regulator_en,
  input wire logic low_voltage_clear_margin_sel,
  input wire logic high_voltage_clear_margin_sel,
  input wire logic startup_check_pulse,
  input wire logic startup_complete,
  input wire logic thermistor_sense_oe
);
  logic [15:0] cyc_r;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Cycles since the sequence began; the windows allow for sync stages
  always_ff @(posedge core_clk)
  begin
    if (rst || !regulator_en)
      cyc_r <= 16'h0000;
    else
      cyc_r <= cyc_r + 16'h0001;
  end

  sequence gates_off;
    !charge_gate && !discharge_gate;
  endsequence

  a_sag_gates_off: assert property (pins_in.supply_sag [*4] |-> gates_off)
    else $error("gates on during supply sag");
  a_resv_gates_off: assert property ((pins_in.charge_gate_reservoir_low ||
    pins_in.discharge_gate_reservoir_low) [*4] |-> gates_off)
    else $error("gates on with reservoir low");
  a_sysuv_gates_off: assert property (pins_in.sys_undervoltage [*4] |-> gates_off)
    else $error("gates on in system undervoltage");
  a_hold_before_done: assert property (!startup_complete |-> !charge_gate && !discharge_gate &&
    low_voltage_clear_margin_sel && high_voltage_clear_margin_sel)
    else $error("outputs not held before completion");
  a_pulse_time: assert property (startup_check_pulse |->
    cyc_r >= 50 * MS_CYCLES - 3 && cyc_r <= 50 * MS_CYCLES + 3)
    else $error("check pulse at wrong time");
  a_pulse_once: assert property (startup_check_pulse |=> !startup_check_pulse [*8])
    else $error("check pulse repeated");
  a_done_time: assert property ($rose(startup_complete) |->
    cyc_r >= 100 * MS_CYCLES - 3 && cyc_r <= 100 * MS_CYCLES + 3)
    else $error("completion at wrong time");
  a_hv_inhibit: assert property (thermistor_sense_oe |-> !charge_gate && startup_complete)
    else $error("charge gate on while charger inhibited");
endmodule : pps_seq_sva

bind pps_sequencer pps_seq_sva #(.MS_CYCLES(MS_CYCLES)) u_pps_seq_sva (.core_clk(core_clk), .rst(rst),
  .pins_in(pins_in), .charge_gate(charge_gate), .discharge_gate(discharge_gate), .regulator_en(regulator_en),
  .low_voltage_clear_margin_sel(low_voltage_clear_margin_sel),
  .high_voltage_clear_margin_sel(high_voltage_clear_margin_sel), .startup_check_pulse(startup_check_pulse),
  .startup_complete(startup_complete), .thermistor_sense_oe(thermistor_sense_oe));

`default_nettype wire

/* File: bench/pps_pack.sv */
`timescale 1ns/1ns
`default_nettype none

module pps_pack (
  // Clock
  input wire logic core_clk,
  // Conditions set by the bench
  input wire pps_pkg::pps_pins_t knob,
  // Thermistor pin pull-low from the block
  input wire logic thermistor_sense_oe,
  // Levels seen by the block
  output var pps_pkg::pps_pins_t pins_in
);
  // Cells settle after the edge; a pulled thermistor pin stops the charger
  always_ff @(posedge core_clk)
  begin
    pins_in <= knob;
    pins_in.charger_detect <= knob.charger_detect && !thermistor_sense_oe;
  end
endmodule : pps_pack

`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic core_clk, rst, cg, dg, reg_en, lvs, hvs, pls, done, ts_oe, ts_o;
  pps_pkg::pps_pins_t knob, pins_in;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  int fails, checks, cyc;

  pps_sequencer #(.MS_CYCLES(10), .THERM_PERIOD_MS(2)) u_pps_sequencer (.core_clk(core_clk), .rst(rst),
    .pins_in(pins_in), .charge_gate(cg), .discharge_gate(dg), .regulator_en(reg_en),
    .low_voltage_clear_margin_sel(lvs), .high_voltage_clear_margin_sel(hvs), .startup_check_pulse(pls),
    .startup_complete(done), .thermistor_sense_out(ts_o), .thermistor_sense_oe(ts_oe), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pps_pack u_pps_pack (.core_clk(core_clk), .knob(knob), .thermistor_sense_oe(ts_oe), .pins_in(pins_in));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Ready lines idle high, so each valid is taken at the first edge; the wait ends on the response
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    r = 2'h3;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        break;
      end
    end
  endtask : wr

  task automatic rd(input string s, input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    araddr <= a;
    arvalid <= 1'b1;
    d = 32'h0;
    r = 2'h3;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    chk(s, e, d);
    chk({s, " resp"}, er, r);
  endtask : rd

  task automatic t_startup;
    int p;
    p = 0;
    knob.late_fault <= 1'b1;
    for (int n = 0; n < 1500 && done !== 1'b1; n++)
    begin
      @(posedge core_clk);
      if (pls === 1'b1) p++;
      if (n == 800) knob.late_fault <= 1'b0;
    end
    chk("check pulses", 32'h1, p);
    chk("done", 32'h1, done);
    tick(1);
    chk("normal outputs", 32'hC, {cg, dg, lvs, hvs});
    rd("status", 4'h4, 32'hE1, 2'h0);
    $display("startup test done");
  endtask : t_startup

  task automatic t_regs;
    wr(4'h0, 32'h7);
    chk("cfg write resp", 32'h0, r);
    rd("cfg", 4'h0, 32'h7, 2'h0);
    wr(4'h4, 32'hFFFF);
    chk("status write resp", 32'h0, r);
    rd("status kept", 4'h4, 32'hE1, 2'h0);
    wr(4'h8, 32'h1);
    chk("unmapped write resp", 32'h2, r);
    rd("unmapped", 4'hC, 32'h0, 2'h2);
    wr(4'h0, 32'h0);
    $display("register test done");
  endtask : t_regs

  task automatic t_sag;
    for (int i = 0; i < 3; i++)
    begin
      knob[16-i] <= 1'b1;
      tick(6);
      chk("forced off", 32'h0, {cg, dg});
      knob[16-i] <= 1'b0;
      tick(6);
      chk("restored", 32'h3, {cg, dg});
    end
    $display("sag test done");
  endtask : t_sag

  task automatic t_hv;
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h0, i);
      knob.cell_high_voltage <= 1'b1;
      knob.high_voltage_cleared <= 1'b0;
      tick(6);
      chk("hv outputs", {29'h1, i[0], 1'b0}, {cg, dg, ts_oe, ts_o});
      knob.cell_high_voltage <= 1'b0;
      knob.high_voltage_cleared <= 1'b1;
      tick(6);
      chk("hv recover", 32'hD, {cg, dg, ts_oe, done});
    end
    $display("high voltage test done");
  endtask : t_hv

  task automatic t_lv;
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h0, i << 1);
      knob.cell_low_voltage <= 1'b1;
      knob.low_voltage_cleared <= 1'b0;
      knob.load_present <= 1'b1;
      tick(6);
      chk("lv off", 32'h0, {cg, dg});
      knob.charger_detect <= 1'b1;
      tick(6);
      chk("lv charger", 32'h2, {cg, dg});
      knob.charger_detect <= 1'b0;
      knob.cell_low_voltage <= 1'b0;
      knob.low_voltage_cleared <= 1'b1;
      tick(6);
      chk("lv load held", i ? 32'h0 : 32'h3, {cg, dg});
      knob.load_present <= 1'b0;
      tick(6);
      chk("lv recover", 32'h3, {cg, dg});
    end
    wr(4'h0, 32'h0);
    $display("low voltage test done");
  endtask : t_lv

  task automatic t_ot;
    knob.below_hot_limit <= 1'b1;
    knob.above_hot_clear <= 1'b0;
    tick(10);
    chk("hot early", 32'h3, {cg, dg});
    tick(60);
    chk("hot off", 32'h0, {cg, dg});
    knob.below_hot_limit <= 1'b0;
    knob.above_hot_clear <= 1'b1;
    tick(70);
    chk("hot recover", 32'h3, {cg, dg});
    $display("temperature test done");
  endtask : t_ot

  task automatic t_shutdown;
    knob.sys_undervoltage <= 1'b1;
    tick(6);
    chk("shutdown", 32'h0, {cg, dg, reg_en});
    knob.sys_undervoltage <= 1'b0;
    knob.cell_low_voltage_raw <= 1'b1;
    knob.cell_low_voltage <= 1'b1;
    knob.low_voltage_cleared <= 1'b0;
    knob.charger_detect <= 1'b1;
    tick(8);
    chk("restart", 32'h3, {done, lvs, hvs});
    for (int n = 0; n < 1500 && done !== 1'b1; n++) @(posedge core_clk);
    tick(1);
    chk("lv after check", 32'h6, {done, cg, dg});
    rd("fault status", 4'h4, 32'h163, 2'h0);
    knob.cell_low_voltage_raw <= 1'b0;
    knob.cell_low_voltage <= 1'b0;
    knob.low_voltage_cleared <= 1'b1;
    knob.charger_detect <= 1'b0;
    tick(6);
    chk("back to normal", 32'h3, {cg, dg});
    $display("shutdown test done");
  endtask : t_shutdown

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Cut a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      final_report();
    end
  end

  // Main sequence
  initial
  begin
    {fails, checks} = '0;
    knob = '0;
    knob.low_voltage_cleared = 1'b1;
    knob.high_voltage_cleared = 1'b1;
    knob.above_hot_clear = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {wstrb, bready, rready, rst} = 7'h7F;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_startup();
    t_regs();
    t_sag();
    t_hv();
    t_lv();
    t_ot();
    t_shutdown();
    final_report();
  end
endmodule : tb

`default_nettype wire
